// File: core/mtu_cfg.svh
// constants of the four-channel timer unit
// assumes inclusion by the package and by every design module
`ifndef MTU_CFG_SVH
`define MTU_CFG_SVH
`define MTU_CHANNELS 4
`define MTU_CNT_W 16
`define MTU_PRE_W 4
`define MTU_DIV_W 16
`define MTU_CNT_RST 16'hFFFF
`define MTU_CDR_RST 16'hFFFF
`define MTU_PRE_RST 16'h0000
`define MTU_EDGE_FALL 2'h0
`define MTU_EDGE_RISE 2'h1
`define MTU_EDGE_BOTH 2'h2
`define MTU_WAKE_MIN_CNT 16'h0096
`define MTU_BREAK_MIN_CNT 16'h000B
`define MTU_DIV_CH 0
`define MTU_SPLIT_CH_A 1
`define MTU_SPLIT_CH_B 3
`define MTU_BYTE_W 8
`endif

// File: core/mtu_pkg.sv
// types of the four-channel timer unit
// assumes mtu_cfg.svh alongside for the numeric constants
`include "mtu_cfg.svh"
package mtu_pkg;
   // channel operating modes
   typedef enum logic [3:0] {
      MTU_INTERVAL,
      MTU_SQUARE,
      MTU_EVENT,
      MTU_DIVIDER,
      MTU_PULSE_INT,
      MTU_WIDTH,
      MTU_DELAY,
      MTU_OS_MASTER,
      MTU_OS_SLAVE,
      MTU_PWM_MASTER,
      MTU_PWM_SLAVE
   } mtu_mode_e;
   // receive line measurement states
   typedef enum logic [2:0] {
      MTU_LIN_IDLE,
      MTU_LIN_WAKE_LOW,
      MTU_LIN_WAIT_BREAK,
      MTU_LIN_BREAK_LOW,
      MTU_LIN_SYNC_WAIT,
      MTU_LIN_SYNC_LOW,
      MTU_LIN_SYNC_HIGH
   } mtu_lin_e;
   // valid edge selection code
   typedef logic [1:0] mtu_edge_t;
endpackage

// File: core/mtu_prescale.sv
// prescaler: free divider giving two selectable count enables
// assumes one clock, selects held steady by the user
`timescale 1ns/1ps
`default_nettype none
`include "mtu_cfg.svh"
module mtu_prescale #(
   parameter int PRE_W = `MTU_PRE_W,
   parameter int DIV_W = `MTU_DIV_W
) (
   input wire logic ref_clk, // unit clock
   input wire logic rstn, // async reset, low active
   input wire logic [PRE_W-1:0] pre_sel0, // log2 of divide for tick0
   input wire logic [PRE_W-1:0] pre_sel1, // log2 of divide for tick1
   output logic tick0, // enable pulse, rate 0
   output logic tick1 // enable pulse, rate 1
);
   logic [DIV_W-1:0] div; // free running divider
   logic [DIV_W-1:0] next_div; // divider next
   logic next_tick0; // tick0 next
   logic next_tick1; // tick1 next

   // low bits all ones once per 2**sel clocks
   function automatic logic tick_hit(input logic [DIV_W-1:0] d, input logic [PRE_W-1:0] s);
      logic [DIV_W-1:0] m;
      m = DIV_W'((DIV_W'(1) << s) - DIV_W'(1));
      return (d & m) == m;
   endfunction

   // divider step and tick decode
   always_comb begin
      next_div = div + 1'b1;
      next_tick0 = tick_hit(div, pre_sel0);
      next_tick1 = tick_hit(div, pre_sel1);
   end

   // register divider and ticks
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         div <= `MTU_PRE_RST;
         tick0 <= 1'b0;
         tick1 <= 1'b0;
      end else begin
         div <= next_div;
         tick0 <= next_tick0;
         tick1 <= next_tick1;
      end
   end
endmodule // mtu_prescale
`default_nettype wire

// File: core/mtu_lin.sv
// receive line measurement: wake-up, break and sync field widths
// assumes rx_line synchronous to ref_clk, tick from the prescaler
`timescale 1ns/1ps
`default_nettype none
`include "mtu_cfg.svh"
module mtu_lin #(
   parameter int CW = `MTU_CNT_W,
   parameter logic [CW-1:0] WAKE_MIN = `MTU_WAKE_MIN_CNT,
   parameter logic [CW-1:0] BREAK_MIN = `MTU_BREAK_MIN_CNT
) (
   input wire logic ref_clk, // unit clock
   input wire logic rstn, // async reset, low active
   input wire logic lin_en, // measurement enable
   input wire logic tick, // width count enable
   input wire logic rx_line, // serial receive line
   output logic wake_det, // pulse: wake-up seen
   output logic break_det, // pulse: break field seen
   output logic sync_done, // pulse: sync widths captured
   output logic [CW-1:0] sync_low, // sync start-bit low width
   output logic [CW-1:0] sync_high, // sync first high width
   output logic ext_irq // pulse: first falling edge
);
   import mtu_pkg::*;
   mtu_lin_e state, next_state; // sequence state
   logic [CW-1:0] width, next_width; // width counter
   logic rx_q; // previous line level
   logic next_wake, next_break, next_done, next_ext; // pulse nexts
   logic [CW-1:0] next_sync_low, next_sync_high; // capture nexts
   logic fall, rise; // line edges

   // sequence through wake-up, break and sync
   always_comb begin
      fall = rx_q & ~rx_line;
      rise = ~rx_q & rx_line;
      next_state = state;
      next_width = (tick && width != '1) ? width + 1'b1 : width;
      next_wake = 1'b0;
      next_break = 1'b0;
      next_done = 1'b0;
      next_ext = 1'b0;
      next_sync_low = sync_low;
      next_sync_high = sync_high;
      if (!lin_en) begin
         next_state = MTU_LIN_IDLE;
      end else begin
         unique case (state)
            MTU_LIN_IDLE: if (fall) begin
               next_ext = 1'b1;
               next_width = '0;
               next_state = MTU_LIN_WAKE_LOW;
            end
            MTU_LIN_WAKE_LOW: if (rise) begin
               next_wake = (width >= WAKE_MIN);
               next_state = (width >= WAKE_MIN) ? MTU_LIN_WAIT_BREAK : MTU_LIN_IDLE;
            end
            MTU_LIN_WAIT_BREAK: if (fall) begin
               next_width = '0;
               next_state = MTU_LIN_BREAK_LOW;
            end
            MTU_LIN_BREAK_LOW: if (rise) begin
               next_break = (width >= BREAK_MIN);
               next_state = (width >= BREAK_MIN) ? MTU_LIN_SYNC_WAIT : MTU_LIN_WAIT_BREAK;
            end
            MTU_LIN_SYNC_WAIT: if (fall) begin
               next_width = '0;
               next_state = MTU_LIN_SYNC_LOW;
            end
            MTU_LIN_SYNC_LOW: if (rise) begin
               next_sync_low = width;
               next_width = '0;
               next_state = MTU_LIN_SYNC_HIGH;
            end
            MTU_LIN_SYNC_HIGH: if (fall) begin
               next_sync_high = width;
               next_done = 1'b1;
               next_state = MTU_LIN_WAIT_BREAK;
            end
         endcase
      end
   end

   // register sequence state
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state <= MTU_LIN_IDLE;
         width <= '0;
         rx_q <= 1'b1;
         wake_det <= 1'b0;
         break_det <= 1'b0;
         sync_done <= 1'b0;
         ext_irq <= 1'b0;
         sync_low <= '0;
         sync_high <= '0;
      end else begin
         state <= next_state;
         width <= next_width;
         rx_q <= rx_line;
         wake_det <= next_wake;
         break_det <= next_break;
         sync_done <= next_done;
         ext_irq <= next_ext;
         sync_low <= next_sync_low;
         sync_high <= next_sync_high;
      end
   end
endmodule // mtu_lin
`default_nettype wire

// File: core/mtu_top.sv
// four-channel 16-bit timer unit with receive line measurement
// assumes pins synchronous to ref_clk, configuration from plain ports
//
// Overview of operation
// - four independent or linked 16-bit channels
// - interval mode: periodic channel interrupt
// - square mode: toggle output per interrupt
// - event mode: interrupt after counted edges
// - divider mode on channel zero only
// - pulse interval: capture count per edge
// - width mode: start one edge, capture opposite; with both edges selected, rise to next rise
// - delay mode: edge starts, interrupt after delay
// - master sets period, slaves follow it
// - one-shot: programmable delay and width
// - pwm pair: programmable period and duty
// - multiple pwm: one master, several slaves
// - channels one and three split 8-bit, in interval mode only
// - wake-up: low width at least threshold
// - break: next low width at least minimum
// - sync low and high widths captured
// - external pin interrupt on first fall
`timescale 1ns/1ps
`default_nettype none
`include "mtu_cfg.svh"
module mtu_top #(
   parameter int CH = `MTU_CHANNELS,
   parameter int CW = `MTU_CNT_W,
   parameter int PRE_W = `MTU_PRE_W,
   parameter logic [CW-1:0] WAKE_MIN = `MTU_WAKE_MIN_CNT,
   parameter logic [CW-1:0] BREAK_MIN = `MTU_BREAK_MIN_CNT
) (
   input wire logic ref_clk, // unit clock, 50 MHz
   input wire logic rstn, // async reset, low active
   input wire logic [PRE_W-1:0] pre_sel0, // prescale rate 0
   input wire logic [PRE_W-1:0] pre_sel1, // prescale rate 1
   input wire mtu_pkg::mtu_mode_e chan_mode [CH], // mode per channel
   input wire logic [CH-1:0] chan_clk_sel, // 1: use rate 1
   input wire mtu_pkg::mtu_edge_t chan_edge [CH], // valid edge select
   input wire logic [CH-1:0] chan_split, // 8-bit split request
   input wire logic [CH-1:0] chan_start, // start pulse
   input wire logic [CH-1:0] chan_stop, // stop pulse
   input wire logic [CH-1:0] cdr_we, // data register write
   input wire logic [CW-1:0] cdr_wdata, // data register value
   input wire logic [CH-1:0] channel_input_pin, // bit 0 is chan_zero_input_pin
   input wire logic lin_en, // receive measurement enable
   input wire logic lin_rx_line, // serial receive line
   output logic [CH-1:0] channel_irq, // channel interrupt pulses
   output logic [CH-1:0] split_hi_irq, // upper 8-bit interrupt pulses
   output logic [CH-1:0] channel_output_pin, // bit 0 is chan_zero_output_pin
   output logic [CH-1:0] chan_running, // channel started
   output logic [CW-1:0] cdr_rdata [CH], // data registers
   output logic external_pin_irq_zero, // first falling edge pulse
   output logic lin_wake_det, // wake-up pulse
   output logic lin_break_det, // break pulse
   output logic lin_sync_done, // sync captured pulse
   output logic [CW-1:0] lin_sync_low, // sync low width
   output logic [CW-1:0] lin_sync_high // sync high width
);
   import mtu_pkg::*;
   localparam int BW = `MTU_BYTE_W;

   logic tick0, tick1; // prescaled enables
   logic [CW-1:0] cnt [CH]; // channel counters
   logic [CW-1:0] next_cnt [CH]; // counter nexts
   logic [CW-1:0] next_cdr [CH]; // data register nexts
   logic [CH-1:0] arm, next_arm; // measurement or one-shot armed
   logic [CH-1:0] next_run; // running nexts
   logic [CH-1:0] next_out; // output pin nexts
   logic [CH-1:0] next_irq, next_hi; // interrupt nexts
   logic [CH-1:0] pin_q; // previous pin levels
   logic [CH-1:0] tick; // enable per channel
   logic [CH-1:0] hit; // valid edge per channel
   logic [CH-1:0] fire; // master period or delay end
   logic [CH-1:0] mfire; // event of own master
   logic have_m; // a master seen below
   int last_m; // index of latest master

   // valid edge decode
   function automatic logic edge_hit(input logic p, input logic c, input mtu_edge_t s);
      unique case (s)
         `MTU_EDGE_FALL: return p & ~c;
         `MTU_EDGE_RISE: return ~p & c;
         `MTU_EDGE_BOTH: return p ^ c;
         default: return 1'b0;
      endcase
   endfunction

   // opposite edge for width capture
   function automatic mtu_edge_t edge_flip(input mtu_edge_t s);
      return (s == `MTU_EDGE_RISE) ? `MTU_EDGE_FALL : `MTU_EDGE_RISE;
   endfunction

   // master modes set the base timing
   function automatic logic is_master(input mtu_mode_e m);
      return (m == MTU_OS_MASTER) || (m == MTU_PWM_MASTER);
   endfunction

   // split allowed on two channels only
   function automatic logic can_split(input int i);
      return (i == `MTU_SPLIT_CH_A) || (i == `MTU_SPLIT_CH_B);
   endfunction

   // count enable source
   mtu_prescale #(
      .PRE_W(PRE_W)
   ) u_pre (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .pre_sel0(pre_sel0),
      .pre_sel1(pre_sel1),
      .tick0(tick0),
      .tick1(tick1)
   );

   // receive line measurement on rate 0
   mtu_lin #(
      .CW(CW),
      .WAKE_MIN(WAKE_MIN),
      .BREAK_MIN(BREAK_MIN)
   ) u_lin (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .lin_en(lin_en),
      .tick(tick0),
      .rx_line(lin_rx_line),
      .wake_det(lin_wake_det),
      .break_det(lin_break_det),
      .sync_done(lin_sync_done),
      .sync_low(lin_sync_low),
      .sync_high(lin_sync_high),
      .ext_irq(external_pin_irq_zero)
   );

   // channel next state
   always_comb begin
      have_m = 1'b0;
      last_m = 0;
      // enables, edges and master events first
      for (int i = 0; i < CH; i++) begin
         tick[i] = chan_clk_sel[i] ? tick1 : tick0;
         hit[i] = edge_hit(pin_q[i], channel_input_pin[i], chan_edge[i]);
         fire[i] = chan_running[i] && tick[i] && cnt[i] == '0 &&
                   (chan_mode[i] == MTU_PWM_MASTER ||
                    (chan_mode[i] == MTU_OS_MASTER && arm[i]));
      end
      for (int i = 0; i < CH; i++) begin
         mfire[i] = have_m && fire[last_m];
         if (is_master(chan_mode[i])) begin
            have_m = 1'b1;
            last_m = i;
         end
      end
      for (int i = 0; i < CH; i++) begin
         next_cnt[i] = cnt[i];
         next_cdr[i] = cdr_we[i] ? cdr_wdata : cdr_rdata[i];
         next_arm[i] = arm[i];
         next_run[i] = chan_running[i];
         next_out[i] = channel_output_pin[i];
         next_irq[i] = 1'b0;
         next_hi[i] = 1'b0;
         if (chan_start[i]) begin
            // start wins over stop; capture modes count up from zero
            next_run[i] = 1'b1;
            next_arm[i] = 1'b0;
            next_out[i] = 1'b0;
            next_cnt[i] = (chan_mode[i] == MTU_PULSE_INT || chan_mode[i] == MTU_WIDTH)
                          ? '0 : cdr_rdata[i];
         end else if (chan_stop[i]) begin
            next_run[i] = 1'b0;
            next_arm[i] = 1'b0;
         end else if (chan_running[i]) begin
            unique case (chan_mode[i])
               MTU_INTERVAL, MTU_SQUARE, MTU_PWM_MASTER: begin
                  if (can_split(i) && chan_split[i] && chan_mode[i] == MTU_INTERVAL) begin
                     if (tick[i]) begin
                        next_cnt[i][BW-1:0] = (cnt[i][BW-1:0] == '0) ?
                           cdr_rdata[i][BW-1:0] : cnt[i][BW-1:0] - 1'b1;
                        next_cnt[i][CW-1:BW] = (cnt[i][CW-1:BW] == '0) ?
                           cdr_rdata[i][CW-1:BW] : cnt[i][CW-1:BW] - 1'b1;
                        next_irq[i] = (cnt[i][BW-1:0] == '0);
                        next_hi[i] = (cnt[i][CW-1:BW] == '0);
                     end
                  end else if (tick[i]) begin
                     if (cnt[i] == '0) begin
                        next_cnt[i] = cdr_rdata[i];
                        next_irq[i] = 1'b1;
                        if (chan_mode[i] == MTU_SQUARE)
                           next_out[i] = ~channel_output_pin[i];
                     end else begin
                        next_cnt[i] = cnt[i] - 1'b1;
                     end
                  end
               end
               MTU_EVENT, MTU_DIVIDER: begin
                  if (hit[i] && (chan_mode[i] == MTU_EVENT || i == `MTU_DIV_CH)) begin
                     if (cnt[i] == '0) begin
                        next_cnt[i] = cdr_rdata[i];
                        next_irq[i] = 1'b1;
                        if (chan_mode[i] == MTU_DIVIDER)
                           next_out[i] = ~channel_output_pin[i];
                     end else begin
                        next_cnt[i] = cnt[i] - 1'b1;
                     end
                  end
               end
               MTU_PULSE_INT: begin
                  if (hit[i]) begin
                     next_cdr[i] = cnt[i];
                     next_irq[i] = 1'b1;
                     next_cnt[i] = '0;
                  end else if (tick[i] && cnt[i] != '1) begin
                     next_cnt[i] = cnt[i] + 1'b1;
                  end
               end
               MTU_WIDTH: begin
                  if (arm[i]) begin
                     if (edge_hit(pin_q[i], channel_input_pin[i], edge_flip(chan_edge[i]))) begin
                        next_cdr[i] = cnt[i];
                        next_irq[i] = 1'b1;
                        next_arm[i] = 1'b0;
                     end else if (tick[i] && cnt[i] != '1) begin
                        next_cnt[i] = cnt[i] + 1'b1;
                     end
                  end else if (edge_hit(pin_q[i], channel_input_pin[i],
                                        (chan_edge[i] == `MTU_EDGE_FALL) ?
                                        `MTU_EDGE_FALL : `MTU_EDGE_RISE)) begin
                     next_arm[i] = 1'b1;
                     next_cnt[i] = '0;
                  end
               end
               MTU_DELAY, MTU_OS_MASTER: begin
                  if (arm[i]) begin
                     if (tick[i]) begin
                        if (cnt[i] == '0) begin
                           next_irq[i] = 1'b1;
                           next_arm[i] = 1'b0;
                        end else begin
                           next_cnt[i] = cnt[i] - 1'b1;
                        end
                     end
                  end else if (hit[i]) begin
                     next_arm[i] = 1'b1;
                     next_cnt[i] = cdr_rdata[i];
                  end
               end
               MTU_OS_SLAVE, MTU_PWM_SLAVE: begin
                  if (mfire[i]) begin
                     next_cnt[i] = cdr_rdata[i];
                     next_out[i] = (cdr_rdata[i] != '0);
                     next_arm[i] = (cdr_rdata[i] != '0);
                  end else if (arm[i] && tick[i]) begin
                     if (cnt[i] <= CW'(1)) begin
                        next_out[i] = 1'b0;
                        next_irq[i] = 1'b1;
                        next_arm[i] = 1'b0;
                        next_cnt[i] = '0;
                     end else begin
                        next_cnt[i] = cnt[i] - 1'b1;
                     end
                  end
               end
            endcase
         end
         // masters report their own event
         if (fire[i] && is_master(chan_mode[i]))
            next_irq[i] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < CH; i++) begin
            cnt[i] <= `MTU_CNT_RST;
            cdr_rdata[i] <= `MTU_CDR_RST;
         end
         arm <= '0;
         chan_running <= '0;
         channel_output_pin <= '0;
         channel_irq <= '0;
         split_hi_irq <= '0;
         pin_q <= '0;
      end else begin
         for (int i = 0; i < CH; i++) begin
            cnt[i] <= next_cnt[i];
            cdr_rdata[i] <= next_cdr[i];
         end
         arm <= next_arm;
         chan_running <= next_run;
         channel_output_pin <= next_out;
         channel_irq <= next_irq;
         split_hi_irq <= next_hi;
         pin_q <= channel_input_pin;
      end
   end
endmodule // mtu_top
`default_nettype wire

// File: bench/mtu_pins.sv
// pin-side model: timer input pins and receive line
// assumes bench requests changed just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module mtu_pins #(
   parameter int LAG = 1
) (
   input wire logic ref_clk, // unit clock
   input wire logic [3:0] pin_req, // wanted pin levels
   input wire logic rx_req, // wanted receive level
   output logic [3:0] pin, // timer input pins
   output logic rx // receive line, idle high
);
   logic [4:0] d [LAG] = '{default: 5'h10}; // lag line, rx idle high
   // slow or prompt copy of the requests
   always @(posedge ref_clk) begin
      d[0] <= {rx_req, pin_req};
      for (int i = 1; i < LAG; i++) begin
         d[i] <= d[i-1];
      end
   end
   assign {rx, pin} = d[LAG-1];
endmodule // mtu_pins
`default_nettype wire

// File: bench/mtu_assertions.sv
// port checker of the timer unit
// assumes binding onto mtu_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module mtu_chk (
   input wire logic ref_clk, // unit clock
   input wire logic rstn, // async reset
   input wire mtu_pkg::mtu_mode_e chan_mode [4], // modes
   input wire logic [3:0] chan_start, // start pulses
   input wire logic [3:0] chan_stop, // stop pulses
   input wire logic [3:0] channel_irq, // interrupts
   input wire logic [3:0] channel_output_pin, // outputs
   input wire logic [3:0] chan_running, // running flags
   input wire logic lin_rx_line, // receive line
   input wire logic external_pin_irq_zero, // first fall
   input wire logic lin_wake_det, // wake pulse
   input wire logic lin_break_det, // break pulse
   input wire logic lin_sync_done // sync pulse
);
   import mtu_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   a_start_runs: assert property (chan_start[0] |=> chan_running[0])
      else $error("start did not run channel");
   a_stop_halts: assert property (chan_stop[0] && !chan_start[0] |=> !chan_running[0])
      else $error("stop did not halt channel");
   a_irq_running: assert property (channel_irq[0] |-> $past(chan_running[0]))
      else $error("interrupt from idle channel");
   a_square_toggle: assert property (chan_mode[1] == MTU_SQUARE && channel_irq[1]
      |-> channel_output_pin[1] != $past(channel_output_pin[1]))
      else $error("square output did not toggle");
   a_first_fall: assert property (external_pin_irq_zero
      |-> !$past(lin_rx_line) && $past(lin_rx_line, 2))
      else $error("pin interrupt without fall");
   a_wake_rise: assert property (lin_wake_det
      |-> $past(lin_rx_line) && !$past(lin_rx_line, 2))
      else $error("wake without rising edge");
   a_break_rise: assert property (lin_break_det
      |-> $past(lin_rx_line) && !$past(lin_rx_line, 2))
      else $error("break without rising edge");
   a_sync_fall: assert property (lin_sync_done
      |-> !$past(lin_rx_line) && $past(lin_rx_line, 2))
      else $error("sync done without fall");
endmodule // mtu_chk
bind mtu_top mtu_chk chk_u (.*);
`default_nettype wire

// File: bench/tb.sv
// self-checking bench of the timer unit
// assumes mtu_pins as the pin side, short receive thresholds
`timescale 1ns/1ps
`default_nettype none
module tb;
   import mtu_pkg::*;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] pre_sel0 = 4'h0, pre_sel1 = 4'h1, chan_clk_sel = 4'h0, chan_split = 4'h0;
   mtu_mode_e chan_mode [4] = '{default: MTU_INTERVAL};
   mtu_edge_t chan_edge [4] = '{default: 2'h2};
   logic [3:0] chan_start = 4'h0, chan_stop = 4'h0, cdr_we = 4'h0, pin_req = 4'h0;
   logic [15:0] cdr_wdata = 16'h0000;
   logic lin_en = 1'b0, rx_req = 1'b1, lin_rx_line;
   logic [3:0] channel_input_pin, channel_irq, split_hi_irq, channel_output_pin, chan_running;
   logic [15:0] cdr_rdata [4];
   logic [15:0] lin_sync_low, lin_sync_high;
   logic external_pin_irq_zero, lin_wake_det, lin_break_det, lin_sync_done;
   int error_cnt = 0, compares = 0, n, n_ext = 0, n_wk = 0, n_brk = 0, n_syn = 0, n_ev = 0, n2;
   mtu_top #(.WAKE_MIN(16'h0004), .BREAK_MIN(16'h0002)) dut_u (.ref_clk, .rstn, .pre_sel0,
      .pre_sel1, .chan_mode, .chan_clk_sel, .chan_edge, .chan_split, .chan_start, .chan_stop,
      .cdr_we, .cdr_wdata, .channel_input_pin, .lin_en, .lin_rx_line, .channel_irq,
      .split_hi_irq, .channel_output_pin, .chan_running, .cdr_rdata, .external_pin_irq_zero,
      .lin_wake_det, .lin_break_det, .lin_sync_done, .lin_sync_low, .lin_sync_high);
   mtu_pins pins_u (.ref_clk, .pin_req, .rx_req, .pin(channel_input_pin), .rx(lin_rx_line));
   // clock, 20 ns period
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   // pulse tallies
   always @(posedge ref_clk) begin
      n_ext += external_pin_irq_zero;
      n_wk += lin_wake_det;
      n_brk += lin_break_det;
      n_syn += lin_sync_done;
      n_ev += channel_irq[2];
   end
   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rng(input logic [15:0] v, input int lo, input int hi);
      chk({15'h0000, v >= lo && v <= hi}, 16'h0001);
   endtask
   // bounded wait; n ends as cycles waited
   task automatic wait_irq(input int ch);
      n = 0;
      while (channel_irq[ch] !== 1'b1 && n < 200) begin
         cyc(1);
         n++;
      end
      cyc(1);
   endtask
   task automatic load(input int ch, input mtu_mode_e m, input logic [15:0] v);
      chan_mode[ch] = m;
      cdr_we[ch] = 1'b1;
      cdr_wdata = v;
      cyc(1);
      cdr_we[ch] = 1'b0;
      chan_start[ch] = 1'b1;
      cyc(1);
      chan_start[ch] = 1'b0;
      chk(cdr_rdata[ch], v);
      chk({15'h0000, chan_running[ch]}, 16'h0001);
   endtask
   task automatic halt;
      chan_stop = 4'hF;
      cyc(1);
      chan_stop = 4'h0;
      cyc(1);
      chk({12'h000, chan_running}, 16'h0000);
   endtask
   task automatic edge_p(input logic [3:0] m);
      pin_req = pin_req ^ m;
      cyc(4);
   endtask
   task automatic lo(input int a, input int b);
      rx_req = 1'b0;
      cyc(a);
      rx_req = 1'b1;
      cyc(b);
   endtask
   task automatic t_interval;
      load(0, MTU_INTERVAL, 16'h0003);
      wait_irq(0);
      wait_irq(0);
      chk(n[15:0], 16'h0003);
      pre_sel0 = 4'h1;
      wait_irq(0);
      wait_irq(0);
      chk(n[15:0], 16'h0007);
      halt();
      wait_irq(0);
      chk(n[15:0], 16'h00C8);
      pre_sel0 = 4'h0;
   endtask
   task automatic t_square;
      logic o;
      load(1, MTU_SQUARE, 16'h0002);
      wait_irq(1);
      o = channel_output_pin[1];
      wait_irq(1);
      chk({15'h0000, channel_output_pin[1]}, {15'h0000, ~o});
      chk(n[15:0], 16'h0002);
      halt();
   endtask
   task automatic t_event_div;
      logic o, p;
      load(2, MTU_EVENT, 16'h0002);
      repeat (2) edge_p(4'h4);
      chk(n_ev[15:0], 16'h0000);
      edge_p(4'h4);
      chk(n_ev[15:0], 16'h0001);
      load(0, MTU_DIVIDER, 16'h0001);
      load(1, MTU_DIVIDER, 16'h0001);
      o = channel_output_pin[0];
      p = channel_output_pin[1];
      repeat (2) edge_p(4'h3);
      chk({15'h0000, channel_output_pin[0]}, {15'h0000, ~o});
      chk({15'h0000, channel_output_pin[1]}, {15'h0000, p});
      halt();
   endtask
   task automatic t_pwm_pint;
      load(0, MTU_PWM_MASTER, 16'h0007);
      load(1, MTU_PWM_SLAVE, 16'h0003);
      load(2, MTU_PWM_SLAVE, 16'h0005);
      wait_irq(0);
      n = 0;
      n2 = 0;
      repeat (8) begin
         n += channel_output_pin[1];
         n2 += channel_output_pin[2];
         cyc(1);
      end
      chk(n[15:0], 16'h0003);
      chk(n2[15:0], 16'h0005);
      wait_irq(0);
      wait_irq(0);
      chk(n[15:0], 16'h0007);
      chan_edge[3] = 2'h1;
      load(3, MTU_PULSE_INT, 16'h0000);
      edge_p(4'h8);
      edge_p(4'h8);
      cyc(2);
      edge_p(4'h8);
      rng(cdr_rdata[3], 9, 11);
      halt();
   endtask
   task automatic t_split_delay;
      chan_split = 4'h2;
      load(1, MTU_INTERVAL, 16'h0301);
      wait_irq(1);
      wait_irq(1);
      chk(n[15:0], 16'h0001);
      n = 0;
      repeat (8) begin
         n += split_hi_irq[1];
         cyc(1);
      end
      chk(n[15:0], 16'h0002);
      chan_clk_sel = 4'h4;
      load(2, MTU_DELAY, 16'h0002);
      edge_p(4'h4);
      wait_irq(2);
      rng(n[15:0], 3, 4);
      load(2, MTU_OS_MASTER, 16'h0002);
      load(3, MTU_OS_SLAVE, 16'h0003);
      edge_p(4'h4);
      n = 0;
      repeat (20) begin
         n += channel_output_pin[3];
         cyc(1);
      end
      chk(n[15:0], 16'h0003);
      chan_edge[3] = 2'h0;
      load(3, MTU_WIDTH, 16'h0000);
      repeat (2) edge_p(4'h8);
      rng(cdr_rdata[3], 3, 5);
      halt();
   endtask
   task automatic t_lin;
      lin_en = 1'b1;
      cyc(2);
      lo(2, 4);
      lo(8, 4);
      lo(5, 4);
      lo(6, 6);
      lo(2, 4);
      chk(n_ext[15:0], 16'h0002);
      chk(n_wk[15:0], 16'h0001);
      chk(n_brk[15:0], 16'h0001);
      chk(n_syn[15:0], 16'h0001);
      rng(lin_sync_low, 4, 7);
      rng(lin_sync_high, 4, 7);
   endtask
   task automatic final_report;
      $display("errors %0d of %0d compares", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // watchdog against hangs
   initial begin
      #200000;
      error_cnt++;
      final_report();
   end
   // reset for 5 cycles, then the scenarios
   initial begin
      cyc(5);
      rstn = 1'b1;
      cyc(1);
      t_interval();
      t_square();
      t_event_div();
      t_pwm_pint();
      t_split_delay();
      t_lin();
      final_report();
   end
endmodule // tb
`default_nettype wire
